// *** rtl/capm_defs.vh ***
`ifndef CAPM_DEFS_VH
`define CAPM_DEFS_VH
// register offsets (word index on the plain port)
`define CAPM_OFF_CLKSEL    4'h0
`define CAPM_OFF_BUSCTL    4'h1
`define CAPM_OFF_PA_PER    4'h2
`define CAPM_OFF_PA_DDR    4'h3
`define CAPM_OFF_PA_DOUT   4'h4
`define CAPM_OFF_PA_PUR    4'h5
`define CAPM_OFF_PA_DIN    4'h6
`define CAPM_OFF_PB_PER    4'h7
`define CAPM_OFF_PB_DDR    4'h8
`define CAPM_OFF_PB_DOUT   4'h9
`define CAPM_OFF_PB_PUR    4'hA
`define CAPM_OFF_PB_DIN    4'hB
`define CAPM_OFF_STATUS    4'hC
// clock select codes
`define CAPM_CLK_OFF       3'h0
`define CAPM_CLK_MASTER    3'h1
`define CAPM_CLK_PERIPH    3'h2
`define CAPM_CLK_OSC       3'h3
`define CAPM_CLK_PRESCALE  3'h4
`define CAPM_CLK_POSTSCALE 3'h5
// field positions
`define CAPM_BUSCTL_DRV    0
`define CAPM_CLKSEL_PB4    3
// reset values
`define CAPM_RST_CLKSEL    4'h0
`define CAPM_RST_BUSCTL    1'h1
`define CAPM_RST_PA_PER    6'h3F
`define CAPM_RST_PA_DDR    6'h00
`define CAPM_RST_PA_PUR    6'h3F
`define CAPM_RST_PB_PER    5'h00
`define CAPM_RST_PB_DDR    5'h00
`define CAPM_RST_PB_PUR    5'h1F
`endif

// *** rtl/capm_pin_mux.v ***
`timescale 1ns/1ns
// Contract
// - clock pin drives buffered clock chosen by select register, or nothing; select codes 6 and 7 drive it low instead
// - port A address lines float when bus idle if drive bit clear
// - port B address lines float when bus idle if drive bit clear
// - port A shared pins default to address function after reset
// - each port A pin independently input or output
// - clearing port A pull-up bit disables that pin's pull-up
// - port B pins reset as inputs with pull-ups, not address
// - each port B pin independently input or output
// - clearing port B pull-up bit n disables pull-up on pin n
// - peripheral enable hands pin to alternate function; on port B pin 4 the select register picks address or prescaler clock
`include "capm_defs.vh"
module capm_pin_mux (
  input  wire        clk,
  input  wire        rst,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire        master_system_clock,
  input  wire        peripheral_bus_clock,
  input  wire        osc_clock,
  input  wire        prescaler_clock,
  input  wire        postscaler_clock,
  input  wire        ext_bus_active,
  input  wire [5:0]  addr_group_one,
  input  wire [3:0]  addr_group_two,
  output reg         clock_out_pin,
  output reg         clock_out_oe,
  output reg  [5:0]  port_a_out,
  output reg  [5:0]  port_a_oe,
  output reg  [5:0]  port_a_pullup,
  input  wire [5:0]  port_a_in,
  output reg  [4:0]  port_b_out,
  output reg  [4:0]  port_b_oe,
  output reg  [4:0]  port_b_pullup,
  input  wire [4:0]  port_b_in
);
  reg  [3:0]  clock_out_select_reg;
  reg         bus_drive_control_bit;
  reg  [5:0]  pa_per;
  reg  [5:0]  pa_ddr;
  reg  [5:0]  pa_dout;
  reg  [5:0]  port_a_pullup_reg;
  reg  [4:0]  port_b_peripheral_enable_reg;
  reg  [4:0]  pb_ddr;
  reg  [4:0]  pb_dout;
  reg  [4:0]  port_b_pullup_reg;
  reg  [5:0]  pa_s1;
  reg  [5:0]  pa_s2;
  reg  [5:0]  pa_s3;
  reg  [5:0]  pa_val;
  reg  [4:0]  pb_s1;
  reg  [4:0]  pb_s2;
  reg  [4:0]  pb_s3;
  reg  [4:0]  pb_val;
  reg         next_clk;
  reg         addr_drive;
  reg  [5:0]  next_pa_out;
  reg  [5:0]  next_pa_oe;
  reg  [4:0]  next_pb_out;
  reg  [4:0]  next_pb_oe;
  reg  [15:0] next_rdata;
  integer     i;

  // register writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_out_select_reg         <= `CAPM_RST_CLKSEL;
      bus_drive_control_bit        <= `CAPM_RST_BUSCTL;
      pa_per                       <= `CAPM_RST_PA_PER;
      pa_ddr                       <= `CAPM_RST_PA_DDR;
      pa_dout                      <= 6'h00;
      port_a_pullup_reg            <= `CAPM_RST_PA_PUR;
      port_b_peripheral_enable_reg <= `CAPM_RST_PB_PER;
      pb_ddr                       <= `CAPM_RST_PB_DDR;
      pb_dout                      <= 5'h00;
      port_b_pullup_reg            <= `CAPM_RST_PB_PUR;
    end else if (wr) begin
      if (addr == `CAPM_OFF_CLKSEL) begin
        clock_out_select_reg <= wdata[3:0];
      end else if (addr == `CAPM_OFF_BUSCTL) begin
        bus_drive_control_bit <= wdata[`CAPM_BUSCTL_DRV];
      end else if (addr == `CAPM_OFF_PA_PER) begin
        pa_per <= wdata[5:0];
      end else if (addr == `CAPM_OFF_PA_DDR) begin
        pa_ddr <= wdata[5:0];
      end else if (addr == `CAPM_OFF_PA_DOUT) begin
        pa_dout <= wdata[5:0];
      end else if (addr == `CAPM_OFF_PA_PUR) begin
        port_a_pullup_reg <= wdata[5:0];
      end else if (addr == `CAPM_OFF_PB_PER) begin
        port_b_peripheral_enable_reg <= wdata[4:0];
      end else if (addr == `CAPM_OFF_PB_DDR) begin
        pb_ddr <= wdata[4:0];
      end else if (addr == `CAPM_OFF_PB_DOUT) begin
        pb_dout <= wdata[4:0];
      end else if (addr == `CAPM_OFF_PB_PUR) begin
        port_b_pullup_reg <= wdata[4:0];
      end
    end
  end

  // pin input synchronisers, change taken when stages two and three agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pa_s1  <= 6'h00;
      pa_s2  <= 6'h00;
      pa_s3  <= 6'h00;
      pa_val <= 6'h00;
      pb_s1  <= 5'h00;
      pb_s2  <= 5'h00;
      pb_s3  <= 5'h00;
      pb_val <= 5'h00;
    end else begin
      pa_s1 <= port_a_in;
      pa_s2 <= pa_s1;
      pa_s3 <= pa_s2;
      pb_s1 <= port_b_in;
      pb_s2 <= pb_s1;
      pb_s3 <= pb_s2;
      for (i = 0; i < 6; i = i + 1) begin
        if (pa_s2[i] == pa_s3[i]) begin
          pa_val[i] <= pa_s3[i];
        end
      end
      for (i = 0; i < 5; i = i + 1) begin
        if (pb_s2[i] == pb_s3[i]) begin
          pb_val[i] <= pb_s3[i];
        end
      end
    end
  end

  // clock source choice
  always @* begin
    case (clock_out_select_reg[2:0])
      `CAPM_CLK_MASTER:    next_clk = master_system_clock;
      `CAPM_CLK_PERIPH:    next_clk = peripheral_bus_clock;
      `CAPM_CLK_OSC:       next_clk = osc_clock;
      `CAPM_CLK_PRESCALE:  next_clk = prescaler_clock;
      `CAPM_CLK_POSTSCALE: next_clk = postscaler_clock;
      default:             next_clk = 1'b0;
    endcase
  end

  // address lines float when the bus is idle and drive bit is clear
  always @* begin
    addr_drive = ext_bus_active | bus_drive_control_bit;
  end

  // pad muxing: address function takes the pin away from gpio
  always @* begin
    next_pa_out      = (pa_per & addr_group_one) | (~pa_per & pa_dout);
    next_pa_oe       = (pa_per & {6{addr_drive}}) | (~pa_per & pa_ddr);
    next_pb_out[3:0] = (port_b_peripheral_enable_reg[3:0] & addr_group_two)
                     | (~port_b_peripheral_enable_reg[3:0] & pb_dout[3:0]);
    next_pb_oe[3:0]  = (port_b_peripheral_enable_reg[3:0] & {4{addr_drive}})
                     | (~port_b_peripheral_enable_reg[3:0] & pb_ddr[3:0]);
    // pin 4: address or prescaler clock, picked by the select register
    if (port_b_peripheral_enable_reg[4]) begin
      if (clock_out_select_reg[`CAPM_CLKSEL_PB4]) begin
        next_pb_out[4] = prescaler_clock;
        next_pb_oe[4]  = 1'b1;
      end else begin
        next_pb_out[4] = 1'b0;
        next_pb_oe[4]  = addr_drive;
      end
    end else begin
      next_pb_out[4] = pb_dout[4];
      next_pb_oe[4]  = pb_ddr[4];
    end
  end

  // read mux
  always @* begin
    next_rdata = 16'h0000;
    if (addr == `CAPM_OFF_CLKSEL) begin
      next_rdata = {12'h000, clock_out_select_reg};
    end else if (addr == `CAPM_OFF_BUSCTL) begin
      next_rdata = {15'h0000, bus_drive_control_bit};
    end else if (addr == `CAPM_OFF_PA_PER) begin
      next_rdata = {10'h000, pa_per};
    end else if (addr == `CAPM_OFF_PA_DDR) begin
      next_rdata = {10'h000, pa_ddr};
    end else if (addr == `CAPM_OFF_PA_DOUT) begin
      next_rdata = {10'h000, pa_dout};
    end else if (addr == `CAPM_OFF_PA_PUR) begin
      next_rdata = {10'h000, port_a_pullup_reg};
    end else if (addr == `CAPM_OFF_PA_DIN) begin
      next_rdata = {10'h000, pa_val};
    end else if (addr == `CAPM_OFF_PB_PER) begin
      next_rdata = {11'h000, port_b_peripheral_enable_reg};
    end else if (addr == `CAPM_OFF_PB_DDR) begin
      next_rdata = {11'h000, pb_ddr};
    end else if (addr == `CAPM_OFF_PB_DOUT) begin
      next_rdata = {11'h000, pb_dout};
    end else if (addr == `CAPM_OFF_PB_PUR) begin
      next_rdata = {11'h000, port_b_pullup_reg};
    end else if (addr == `CAPM_OFF_PB_DIN) begin
      next_rdata = {11'h000, pb_val};
    end else if (addr == `CAPM_OFF_STATUS) begin
      next_rdata = {14'h0000, clock_out_oe, addr_drive};
    end
  end

  // registered outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata         <= 16'h0000;
      clock_out_pin <= 1'b0;
      clock_out_oe  <= 1'b0;
      port_a_out    <= 6'h00;
      port_a_oe     <= 6'h00;
      port_a_pullup <= `CAPM_RST_PA_PUR;
      port_b_out    <= 5'h00;
      port_b_oe     <= 5'h00;
      port_b_pullup <= `CAPM_RST_PB_PUR;
    end else begin
      rdata         <= rd ? next_rdata : 16'h0000;
      clock_out_pin <= next_clk;
      clock_out_oe  <= (clock_out_select_reg[2:0] != `CAPM_CLK_OFF);
      port_a_out    <= next_pa_out;
      port_a_oe     <= next_pa_oe;
      port_a_pullup <= port_a_pullup_reg & ~next_pa_oe;
      port_b_out    <= next_pb_out;
      port_b_oe     <= next_pb_oe;
      port_b_pullup <= port_b_pullup_reg & ~next_pb_oe;
    end
  end
endmodule

// *** test/capm_pin_mux_sva.sv ***
`timescale 1ns/1ns
// pin-level checks on the pin mux
module capm_pin_mux_sva (
  input wire        clk,
  input wire        rst,
  input wire [3:0]  addr,
  input wire [15:0] wdata,
  input wire        wr,
  input wire [5:0]  addr_group_one,
  input wire        clock_out_oe,
  input wire [5:0]  port_a_out,
  input wire [5:0]  port_a_oe,
  input wire [5:0]  port_a_pullup,
  input wire [4:0]  port_b_oe,
  input wire [4:0]  port_b_pullup
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rst_quiet: assert property ($past(rst) |-> !clock_out_oe && port_a_oe == 6'h00)
    else $error("driver on at reset release");
  a_clk_sel: assert property (wr && addr == 4'h0 ##1 !(wr && addr == 4'h0)
    |=> clock_out_oe == (($past(wdata, 2) & 16'h0007) != 16'h0000))
    else $error("clock pin enable wrong");
  a_pa_default: assert property ($fell(rst) |-> ##2 port_a_oe == 6'h3F)
    else $error("port a not in address use");
  a_pa_addr: assert property ($fell(rst) |-> ##2 port_a_out == $past(addr_group_one))
    else $error("port a address value wrong");
  a_pb_input: assert property ($fell(rst) |-> ##1 port_b_oe == 5'h00 ##1 port_b_oe == 5'h00)
    else $error("port b drives after reset");
  a_pb_pullup: assert property ($fell(rst) |-> ##1 port_b_pullup == 5'h1F)
    else $error("port b pull-ups off after reset");
  a_pua_drive: assert property ((port_a_oe & port_a_pullup) == 6'h00)
    else $error("port a pull-up on driven pin");
  a_pub_drive: assert property ((port_b_oe & port_b_pullup) == 5'h00)
    else $error("port b pull-up on driven pin");
endmodule
bind capm_pin_mux capm_pin_mux_sva u_sva (
  .clk            (clk),
  .rst            (rst),
  .addr           (addr),
  .wdata          (wdata),
  .wr             (wr),
  .addr_group_one (addr_group_one),
  .clock_out_oe   (clock_out_oe),
  .port_a_out     (port_a_out),
  .port_a_oe      (port_a_oe),
  .port_a_pullup  (port_a_pullup),
  .port_b_oe      (port_b_oe),
  .port_b_pullup  (port_b_pullup)
);

// *** test/capm_ext_mem.sv ***
`timescale 1ns/1ns
// memory side of the shared pads: it only listens to the lines
module capm_ext_mem #(
  parameter W = 6
) (
  input  wire         clk,
  input  wire [W-1:0] out,
  input  wire [W-1:0] oe,
  input  wire [W-1:0] pull_en,
  output wire [W-1:0] pad
);
  reg [W-1:0] junk = {W{1'b0}};
  // a floating line wanders every cycle
  always @(posedge clk) begin
    junk <= ~junk;
  end
  // pad level: driver, else pull-up, else noise
  assign pad = (oe & out) | (~oe & pull_en) | (~oe & ~pull_en & junk);
endmodule

// *** test/clock_out_and_address_pin_mux_bench.sv ***
`timescale 1ns/1ns
module clock_out_and_address_pin_mux_bench;
  reg         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ext_bus_active = 1'b0, p, e;
  reg  [3:0]  addr = 4'h0, addr_group_two = 4'h0, b;
  reg  [15:0] wdata = 16'h0000, r, d, u, m, v;
  reg  [4:0]  src = 5'h00;
  reg  [5:0]  addr_group_one = 6'h00;
  wire [15:0] rdata;
  wire        master_system_clock, peripheral_bus_clock, osc_clock;
  wire        prescaler_clock, postscaler_clock, clock_out_pin, clock_out_oe;
  wire [5:0]  port_a_out, port_a_oe, port_a_pullup, port_a_in;
  wire [4:0]  port_b_out, port_b_oe, port_b_pullup, port_b_in;
  integer     i, c, miscompares = 0, check_count = 0;
  assign {postscaler_clock, prescaler_clock, osc_clock, peripheral_bus_clock,
          master_system_clock} = src;
  capm_pin_mux dut (
    .clk                  (clk),
    .rst                  (rst),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .master_system_clock  (master_system_clock),
    .peripheral_bus_clock (peripheral_bus_clock),
    .osc_clock            (osc_clock),
    .prescaler_clock      (prescaler_clock),
    .postscaler_clock     (postscaler_clock),
    .ext_bus_active       (ext_bus_active),
    .addr_group_one       (addr_group_one),
    .addr_group_two       (addr_group_two),
    .clock_out_pin        (clock_out_pin),
    .clock_out_oe         (clock_out_oe),
    .port_a_out           (port_a_out),
    .port_a_oe            (port_a_oe),
    .port_a_pullup        (port_a_pullup),
    .port_a_in            (port_a_in),
    .port_b_out           (port_b_out),
    .port_b_oe            (port_b_oe),
    .port_b_pullup        (port_b_pullup),
    .port_b_in            (port_b_in)
  );
  capm_ext_mem #(.W(6)) pad_a (.clk(clk), .out(port_a_out), .oe(port_a_oe),
                               .pull_en(port_a_pullup), .pad(port_a_in));
  capm_ext_mem #(.W(5)) pad_b (.clk(clk), .out(port_b_out), .oe(port_b_oe),
                               .pull_en(port_b_pullup), .pad(port_b_in));
  // 50 ns clock
  always #25 clk = ~clk;
  // clock sources as random data
  always @(posedge clk) src <= $urandom;
  function [15:0] rst_val(input [3:0] a);
    rst_val = (a == 4'h1 || a == 4'hC) ? 16'h0001 : (a == 4'h2 || a == 4'h5) ? 16'h003F :
              (a == 4'hA) ? 16'h001F : 16'h0000;
  endfunction
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wreg(input [3:0] a, input [15:0] dw);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= dw;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [3:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // hang guard
  initial begin
    #(50 * 3000);
    miscompares = miscompares + 1;
    results;
  end
  // main sequence
  initial begin
    v = $urandom(6);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      if ((16'hF5AF >> i) & 16'h0001) begin
        rreg(i[3:0]);
        cmp(v, rst_val(i[3:0]));
      end
    end
    $display("test reset values done");
    for (c = 0; c < 6; c = c + 1) begin
      wreg(4'h0, c[15:0]);
      repeat (2) @(posedge clk);
      repeat (8) begin
        @(posedge clk);
        e = (c == 0) ? 1'b0 : src[c-1];
        #1 cmp({clock_out_oe, clock_out_pin & clock_out_oe}, {c != 0, e});
      end
    end
    $display("test clock select done");
    wreg(4'h7, 16'h000F);
    wreg(4'h1, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk);
      ext_bus_active <= i[0];
      addr_group_one <= $urandom;
      addr_group_two <= $urandom;
      repeat (3) @(posedge clk);
      #1 cmp({port_a_oe, port_b_oe[3:0]}, {10{i[0]}});
      cmp({port_a_out & port_a_oe, port_b_out[3:0] & port_b_oe[3:0]},
          {addr_group_one, addr_group_two} & {10{i[0]}});
    end
    $display("test bus idle done");
    // port b pin four shows the prescaler clock, clock pin stays off
    wreg(4'h7, 16'h0010);
    wreg(4'h0, 16'h0008);
    repeat (2) @(posedge clk);
    repeat (8) begin
      @(posedge clk);
      e = src[3];
      #1 cmp({clock_out_oe, port_b_oe[4], port_b_out[4]}, {2'b01, e});
    end
    $display("test pin four clock done");
    for (i = 0; i < 8; i = i + 1) begin
      p = i[0];
      r = $urandom;
      d = $urandom;
      u = $urandom;
      b = p ? 4'h7 : 4'h2;
      m = p ? 16'h001F : 16'h003F;
      wreg(b, 16'h0000);
      wreg(b + 4'h1, r);
      wreg(b + 4'h2, d);
      wreg(b + 4'h3, u);
      repeat (2) @(posedge clk);
      #1 cmp(p ? port_b_oe : port_a_oe, r & m);
      cmp(p ? port_b_out & port_b_oe : port_a_out & port_a_oe, d & r & m);
      cmp(p ? port_b_pullup : port_a_pullup, u & ~r & m);
      // pad levels back through the synchronisers, floating lines masked
      repeat (4) @(posedge clk);
      rreg(b + 4'h4);
      cmp(v & (r | u) & m, ((d & r) | (u & ~r)) & (r | u) & m);
    end
    $display("test gpio done");
    results;
  end
endmodule
